// >>> dv/pap_board.sv
`timescale 1ns/1ps
module pap_board
   import pap_pkg::*;
(
   // clock
   input wire logic sys_clk_i,
   // device side
   input wire pap_pad_t pad_i,
   // board drive
   input wire logic [PA_W-1:0] drv_val_i,
   input wire logic [PA_W-1:0] drv_en_i,
   // resolved pins
   output logic [PA_W-1:0] pin_o
);
   // ****************************************
   // pin resolution
   // ****************************************
   // no pull-ups on this port, so a line nobody drives wanders every cycle
   logic [PA_W-1:0] float_q = 8'h5A;

   always @(posedge sys_clk_i) begin
      float_q <= ~float_q;
   end

   assign pin_o = (pad_i.oe & pad_i.out) | (~pad_i.oe & drv_en_i & drv_val_i)
                | (~pad_i.oe & ~drv_en_i & float_q);
endmodule : pap_board

// >>> dv/pap_port_a_bench.sv
`timescale 1ns/1ps
module pap_port_a_bench;
   import pap_pkg::*;
   // ****************************************
   // stimulus and observation
   // ****************************************
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [PA_ADDR_W-1:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [7:0] pin;
   pap_pad_t pad;
   logic cyc = 1'b0;
   logic [1:0] div = 2'h0;
   logic tmr;
   logic ecs;
   logic xen;
   logic [4:0] an_en;
   logic [7:0] drv_val = 8'h00;
   logic [7:0] drv_en = 8'h00;
   logic [31:0] rd;
   logic er;
   int comparisons = 0;
   int miscompares = 0;

   always #20 clk = ~clk;
   // cycle clock at a quarter of the system clock
   always @(posedge clk) begin
      div <= div + 2'h1;
      if (div[0]) cyc <= ~cyc;
   end

   pap_port_a i_pap_port_a (.sys_clk_i(clk), .rst_n_i(rst_n), .paddr_i(paddr),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
      .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .pin_i(pin), .pad_o(pad), .cycle_clk_i(cyc), .timer_ext_clock_o(tmr),
      .ext_clock_source_o(ecs), .crystal_en_o(xen), .analog_en_o(an_en));

   pap_board i_pap_board (.sys_clk_i(clk), .pad_i(pad), .drv_val_i(drv_val),
      .drv_en_i(drv_en), .pin_o(pin));

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      // only the watchdog ends a wait for ready
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d}, 4'hF);
   endtask : wr

   task automatic rdc(input string n, input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 32'h0, 4'hF);
      chk(n, rd, {24'h0, e});
   endtask : rdc

   task automatic settle();
      @(posedge clk);
      #1;
   endtask : settle

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      rdc("lat", PA_OFF_LAT, 8'h00);
      rdc("dir", PA_OFF_DIR, 8'hFF);
      rdc("ancfg", PA_OFF_ANCFG, 8'h00);
      chk("an_en", 32'(an_en), 32'h1F);
      chk("oe", 32'(pad.oe), 32'h0);
      drv_en <= 8'hFF;
      drv_val <= 8'hFF;
      repeat (3) @(posedge clk);
      rdc("pins", PA_OFF_PINS, 8'hD0);
   endtask : t_reset

   task automatic t_output();
      wr(PA_OFF_ANCFG, 8'h07);
      drv_en <= 8'h00;
      wr(PA_OFF_PINS, 8'hA5);
      rdc("lat", PA_OFF_LAT, 8'hA5);
      wr(PA_OFF_DIR, 8'h00);
      settle();
      chk("out", 32'(pad.out), 32'hA5);
      chk("oe", 32'(pad.oe), 32'hFF);
      wr(PA_OFF_ANCFG, 8'h00);
      settle();
      chk("out_an", 32'(pad.out), 32'hA5);
      repeat (2) @(posedge clk);
      rdc("pins_an", PA_OFF_PINS, 8'h80);
      wr(PA_OFF_ANCFG, 8'hFF);
      rdc("ancfg", PA_OFF_ANCFG, 8'h3F);
   endtask : t_output

   task automatic t_select();
      logic [4:0] e;
      for (int s = 0; s < 16; s++) begin
         wr(PA_OFF_ANCFG, 8'(s));
         for (int k = 0; k < 5; k++) e[k] = (s < 7 - k);
         settle();
         chk("an_sel", 32'(an_en), 32'(e));
      end
   endtask : t_select

   task automatic t_timer();
      // bit 4 is an output here; the timer still sees the pin
      wr(PA_OFF_PINS, 8'h10);
      settle();
      chk("tmr_early", 32'(tmr), 32'h0);
      settle();
      chk("tmr", 32'(tmr), 32'h1);
   endtask : t_timer

   task automatic t_osc();
      wr(PA_OFF_LAT, 8'hFF);
      wr(PA_OFF_OSCCFG, 8'h03);
      settle();
      chk("oe_ext", 32'(pad.oe), 32'h7F);
      repeat (4) begin
         settle();
         chk("clk_out", 32'(pad.out[6]), 32'(cyc));
      end
      rdc("lat_claim", PA_OFF_LAT, 8'h3F);
      rdc("pins_claim", PA_OFF_PINS, 8'h3F);
      drv_en <= 8'h80;
      drv_val <= 8'h80;
      settle();
      chk("clk_src_hi", 32'(ecs), 32'h1);
      drv_val <= 8'h00;
      settle();
      chk("clk_src_lo", 32'(ecs), 32'h0);
      wr(PA_OFF_LAT, 8'h00);
      wr(PA_OFF_OSCCFG, 8'h01);
      settle();
      chk("xtal", 32'(xen), 32'h1);
      chk("oe_xtal", 32'(pad.oe), 32'h3F);
      wr(PA_OFF_DIR, 8'hFF);
      drv_en <= 8'h00;
      wr(PA_OFF_OSCCFG, 8'h00);
      rdc("lat_kept", PA_OFF_LAT, 8'hC0);
      rdc("dir_kept", PA_OFF_DIR, 8'h3F);
   endtask : t_osc

   task automatic t_bus();
      apb(1'b0, 12'h014, 32'h0, 4'hF);
      chk("err", 32'(er), 32'h1);
      chk("rd_unmapped", rd, 32'h0);
      apb(1'b1, PA_OFF_LAT, 32'h55, 4'h0);
      rdc("lat_nostrb", PA_OFF_LAT, 8'hC0);
   endtask : t_bus

   task automatic t_rereset();
      // a reset in mid-run must bring back the same defaults
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
   endtask : t_rereset

   // ****************************************
   // run control
   // ****************************************
   task automatic tally_and_finish();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      #(40 * 4000);
      miscompares++;
      tally_and_finish();
   end

   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_output();
      t_select();
      t_timer();
      t_osc();
      t_bus();
      t_rereset();
      tally_and_finish();
   end
endmodule : pap_port_a_bench

// >>> hw/pap_analog_map.sv
`timescale 1ns/1ps
module pap_analog_map
   import pap_pkg::*;
(
   // selector
   input wire logic [PA_PCFG_W-1:0] port_analog_select_i,
   // decoded claims
   output logic [PA_AN_CH-1:0] analog_en_o,
   output logic [PA_W-1:0] analog_pin_mask_o
);

   logic [PA_W-1:0] mask_w [PA_AN_CH+1];

   assign mask_w[0] = PA_NO_PINS;

   // higher channels give way first as the selector rises
   for (genvar k = 0; k < PA_AN_CH; k++) begin : g_ch
      assign analog_en_o[k] = int'(port_analog_select_i) < (PA_PCFG_ALL_DIG - k);
      assign mask_w[k+1] = mask_w[k] |
                           (analog_en_o[k] ? PA_W'(1 << PA_AN_CH_PIN[k]) : PA_NO_PINS);
   end

   assign analog_pin_mask_o = mask_w[PA_AN_CH];

endmodule : pap_analog_map

// >>> hw/pap_pkg.sv
package pap_pkg;

   // ****************************************
   // widths
   // ****************************************
   localparam int PA_W = 8;
   localparam int PA_ADDR_W = 12;
   localparam int PA_DATA_W = 32;
   localparam int PA_AN_CH = 5;

   // ****************************************
   // register offsets (byte addresses)
   // ****************************************
   localparam logic [PA_ADDR_W-1:0] PA_OFF_PINS = 12'h000;
   localparam logic [PA_ADDR_W-1:0] PA_OFF_LAT = 12'h004;
   localparam logic [PA_ADDR_W-1:0] PA_OFF_DIR = 12'h008;
   localparam logic [PA_ADDR_W-1:0] PA_OFF_ANCFG = 12'h00C;
   localparam logic [PA_ADDR_W-1:0] PA_OFF_OSCCFG = 12'h010;

   // ****************************************
   // fields and reset values
   // ****************************************
   localparam int PA_ANCFG_W = 6;
   localparam int PA_PCFG_W = 4;
   localparam int PA_OSCCFG_W = 2;
   localparam int PA_OSC_SEL_BIT = 0;
   localparam int PA_OSC_EXT_BIT = 1;
   localparam int PA_TMR_BIT = 4;
   localparam int PA_CLK_OUT_BIT = 6;
   localparam int PA_CLK_IN_BIT = 7;
   localparam logic [PA_W-1:0] PA_OSC_PINS = 8'hC0;
   localparam logic [PA_W-1:0] PA_NO_PINS = 8'h00;
   localparam logic [PA_W-1:0] PA_LAT_RST = 8'h00;
   localparam logic [PA_W-1:0] PA_DIR_RST = 8'hFF;
   localparam logic [PA_ANCFG_W-1:0] PA_ANCFG_RST = 6'h00;
   localparam logic [PA_OSCCFG_W-1:0] PA_OSCCFG_RST = 2'h0;
   localparam logic [PA_AN_CH-1:0] PA_AN_ALL = 5'h1F;

   // selector value from which every channel is digital
   localparam int PA_PCFG_ALL_DIG = 7;
   // pin carrying each analog channel
   localparam int PA_AN_CH_PIN [PA_AN_CH] = '{0, 1, 2, 3, 5};

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic [PA_W-1:0] out;
      logic [PA_W-1:0] oe;
   } pap_pad_t;

   typedef struct packed {
      logic [PA_ADDR_W-1:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [PA_DATA_W-1:0] pwdata;
      logic [3:0] pstrb;
   } pap_apb_req_t;

endpackage : pap_pkg

// >>> hw/pap_port_a.sv
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
module pap_port_a
   import pap_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // apb slave
   input wire logic [PA_ADDR_W-1:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [PA_DATA_W-1:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [PA_DATA_W-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // pins
   input wire logic [PA_W-1:0] pin_i,
   output pap_pad_t pad_o,
   // shared functions
   input wire logic cycle_clk_i,
   output logic timer_ext_clock_o,
   output logic ext_clock_source_o,
   output logic crystal_en_o,
   output logic [PA_AN_CH-1:0] analog_en_o
);

   // ****************************************
   // bus decode
   // ****************************************
   function automatic logic addr_hit(input logic [PA_ADDR_W-1:0] a,
                                     input logic [PA_ADDR_W-1:0] off);
      return a == off;
   endfunction : addr_hit

   pap_apb_req_t req;
   logic hit_pins, hit_lat, hit_dir, hit_ancfg, hit_osccfg, hit_any;
   logic wr_en, wr_lo, setup_rd;

   assign req = '{paddr: paddr_i, psel: psel_i, penable: penable_i, pwrite: pwrite_i,
                  pwdata: pwdata_i, pstrb: pstrb_i};
   assign hit_pins = addr_hit(req.paddr, PA_OFF_PINS);
   assign hit_lat = addr_hit(req.paddr, PA_OFF_LAT);
   assign hit_dir = addr_hit(req.paddr, PA_OFF_DIR);
   assign hit_ancfg = addr_hit(req.paddr, PA_OFF_ANCFG);
   assign hit_osccfg = addr_hit(req.paddr, PA_OFF_OSCCFG);
   assign hit_any = hit_pins | hit_lat | hit_dir | hit_ancfg | hit_osccfg;

   // read data is registered in setup, so access never waits
   assign pready_o = 1'b1;
   assign pslverr_o = req.psel & req.penable & ~hit_any;
   assign wr_en = req.psel & req.penable & req.pwrite & hit_any;
   // only the low byte lane holds register bits
   assign wr_lo = wr_en & req.pstrb[0];
   assign setup_rd = req.psel & ~req.penable & ~req.pwrite;

   // ****************************************
   // registers
   // ****************************************
   logic [PA_W-1:0] lat_q, lat_d;
   logic [PA_W-1:0] dir_q, dir_d;
   logic [PA_ANCFG_W-1:0] ancfg_q, ancfg_d;
   logic [PA_OSCCFG_W-1:0] osccfg_q, osccfg_d;
   logic [PA_DATA_W-1:0] rdata_q, rdata_d;
   logic osc_pin_select_bit, ext_clock_mode, crystal_osc_mode;
   logic [PA_W-1:0] claim_mask, keep_mask;

   assign osc_pin_select_bit = osccfg_q[PA_OSC_SEL_BIT];
   assign ext_clock_mode = osc_pin_select_bit & osccfg_q[PA_OSC_EXT_BIT];
   assign crystal_osc_mode = osc_pin_select_bit & ~osccfg_q[PA_OSC_EXT_BIT];
   assign claim_mask = osc_pin_select_bit ? PA_OSC_PINS : PA_NO_PINS;
   assign keep_mask = ~claim_mask;

   // claimed bits refuse writes so they cannot leak back when released
   assign lat_d = (wr_lo & (hit_pins | hit_lat)) ?
                  ((req.pwdata[PA_W-1:0] & keep_mask) | (lat_q & claim_mask)) : lat_q;
   assign dir_d = (wr_lo & hit_dir) ?
                  ((req.pwdata[PA_W-1:0] & keep_mask) | (dir_q & claim_mask)) : dir_q;
   assign ancfg_d = (wr_lo & hit_ancfg) ? req.pwdata[PA_ANCFG_W-1:0] : ancfg_q;
   assign osccfg_d = (wr_lo & hit_osccfg) ? req.pwdata[PA_OSCCFG_W-1:0] : osccfg_q;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lat_q <= PA_LAT_RST;
         dir_q <= PA_DIR_RST;
         ancfg_q <= PA_ANCFG_RST;
         osccfg_q <= PA_OSCCFG_RST;
      end else begin
         lat_q <= lat_d;
         dir_q <= dir_d;
         ancfg_q <= ancfg_d;
         osccfg_q <= osccfg_d;
      end
   end

   // ****************************************
   // analog claim and input path
   // ****************************************
   logic [PA_W-1:0] analog_pin_mask;
   logic [PA_W-1:0] pin_sync;
   logic [PA_W-1:0] pins_rd;

   pap_analog_map u_analog_map (
      .port_analog_select_i(ancfg_q[PA_PCFG_W-1:0]),
      .analog_en_o(analog_en_o),
      .analog_pin_mask_o(analog_pin_mask)
   );

   pap_sync2 u_sync (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .async_i(pin_i),
      .sync_o(pin_sync)
   );

   assign pins_rd = pin_sync & ~analog_pin_mask & keep_mask;

   // ****************************************
   // read mux
   // ****************************************
   // claimed bits of latch and direction read as zero
   assign rdata_d = hit_pins ? PA_DATA_W'(pins_rd) :
                    hit_lat ? PA_DATA_W'(lat_q & keep_mask) :
                    hit_dir ? PA_DATA_W'(dir_q & keep_mask) :
                    hit_ancfg ? PA_DATA_W'(ancfg_q) :
                    hit_osccfg ? PA_DATA_W'(osccfg_q) : '0;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q <= '0;
      end else if (setup_rd) begin
         rdata_q <= rdata_d;
      end
   end

   assign prdata_o = rdata_q;

   // ****************************************
   // pad drive
   // ****************************************
   logic [PA_W-1:0] pad_out_w, pad_oe_w;

   for (genvar i = 0; i < PA_W; i++) begin : g_pad
      if (i == PA_CLK_OUT_BIT) begin : g_clk_out
         // cycle clock wins over the latch and the direction bit
         assign pad_oe_w[i] = ext_clock_mode | (~dir_q[i] & keep_mask[i]);
         assign pad_out_w[i] = ext_clock_mode ? cycle_clk_i : lat_q[i];
      end else begin : g_plain
         // analog claim never touches the output driver
         assign pad_oe_w[i] = ~dir_q[i] & keep_mask[i];
         assign pad_out_w[i] = lat_q[i];
      end
   end

   assign pad_o = '{out: pad_out_w, oe: pad_oe_w};

   // ****************************************
   // shared pin functions
   // ****************************************
   assign timer_ext_clock_o = pin_sync[PA_TMR_BIT];
   // raw pin so the main clock sees no sampling delay
   assign ext_clock_source_o = ext_clock_mode & pin_i[PA_CLK_IN_BIT];
   assign crystal_en_o = crystal_osc_mode;

   // ****************************************
   // checks
   // ****************************************
   logic [1:0] age_q;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         age_q <= 2'h0;
      end else if (age_q != 2'h3) begin
         age_q <= age_q + 2'h1;
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_setup_rd_ancfg;
      psel_i && !penable_i && !pwrite_i && hit_ancfg;
   endsequence

   sequence s_wr_pins;
      psel_i && penable_i && pwrite_i && pstrb_i[0] && hit_pins && !osc_pin_select_bit;
   endsequence

   sequence s_wr_lat_claimed;
      psel_i && penable_i && pwrite_i && hit_lat && osc_pin_select_bit;
   endsequence

   sequence s_wr_dir_claimed;
      psel_i && penable_i && pwrite_i && hit_dir && osc_pin_select_bit;
   endsequence

   sequence s_acc_unmapped;
      psel_i && penable_i && !hit_any;
   endsequence

   sequence s_wr_no_strobe;
      psel_i && penable_i && pwrite_i && !pstrb_i[0];
   endsequence

   // the synchroniser shows reset values for two edges, so young reads are skipped
   sequence s_setup_rd_pins;
      psel_i && !penable_i && !pwrite_i && hit_pins && (age_q == 2'h3);
   endsequence

   drive_from_latch_a: assert property (
      (pad_o.oe[5:0] == ~dir_q[5:0]) && (pad_o.out[5:0] == lat_q[5:0]))
      else $error("low pins not driven from latch per direction");

   analog_read_zero_a: assert property (
      (pins_rd & analog_pin_mask) == PA_NO_PINS)
      else $error("analog pin leaked into digital read");

   reset_default_a: assert property (
      (age_q == 2'h0) |-> (analog_en_o == PA_AN_ALL) && dir_q[PA_TMR_BIT]
                          && !analog_pin_mask[PA_TMR_BIT])
      else $error("reset configuration wrong");

   osc_claim_a: assert property (
      osc_pin_select_bit |-> !pad_o.oe[PA_CLK_IN_BIT] && (pins_rd[7:6] == 2'b00)
                             && (ext_clock_mode || !pad_o.oe[PA_CLK_OUT_BIT]))
      else $error("claimed oscillator pins still digital");

   cycle_clk_out_a: assert property (
      ext_clock_mode |-> pad_o.oe[PA_CLK_OUT_BIT] && (pad_o.out[PA_CLK_OUT_BIT] == cycle_clk_i))
      else $error("cycle clock not on bit 6");

   timer_feed_a: assert property (
      (age_q == 2'h3) |-> timer_ext_clock_o == $past(pin_i[PA_TMR_BIT], 2))
      else $error("timer clock input not following bit 4");

   claimed_write_a: assert property (
      s_wr_lat_claimed |=> lat_q[7:6] == $past(lat_q[7:6]))
      else $error("write reached a claimed latch bit");

   ancfg_read_a: assert property (
      s_setup_rd_ancfg |=> (prdata_o[PA_DATA_W-1:PA_ANCFG_W] == '0)
                           && (prdata_o[PA_ANCFG_W-1:0] == $past(ancfg_q)))
      else $error("analog configuration read wrong");

   pin_write_latch_a: assert property (
      s_wr_pins |=> lat_q == $past(pwdata_i[PA_W-1:0]))
      else $error("pin register write missed the latch");

   hiz_input_a: assert property (
      (dir_q[PA_TMR_BIT] |-> !pad_o.oe[PA_TMR_BIT]) and (dir_q[0] |-> !pad_o.oe[0]))
      else $error("input pin still driven");

   claimed_dir_a: assert property (
      s_wr_dir_claimed |=> dir_q[7:6] == $past(dir_q[7:6]))
      else $error("write reached a claimed direction bit");

   unmapped_err_a: assert property (
      s_acc_unmapped |-> pslverr_o ##1 ((lat_q == $past(lat_q)) && (dir_q == $past(dir_q))))
      else $error("unmapped access not refused");

   strobe_ignore_a: assert property (
      s_wr_no_strobe |=> (lat_q == $past(lat_q)) && (dir_q == $past(dir_q))
                         && (ancfg_q == $past(ancfg_q)) && (osccfg_q == $past(osccfg_q)))
      else $error("write without low strobe changed a register");

   pins_read_a: assert property (
      s_setup_rd_pins |=> (prdata_o[PA_DATA_W-1:PA_W] == '0) && (prdata_o[PA_W-1:0]
                          == ($past(pin_i, 3) & ~$past(analog_pin_mask) & $past(keep_mask))))
      else $error("pin register read wrong");

   ext_clk_src_a: assert property (
      (ext_clock_mode |-> ext_clock_source_o == pin_i[PA_CLK_IN_BIT])
      and (!ext_clock_mode |-> !ext_clock_source_o))
      else $error("main clock source not taken from bit 7");

   crystal_pins_a: assert property (
      crystal_en_o |-> !pad_o.oe[PA_CLK_OUT_BIT] && !pad_o.oe[PA_CLK_IN_BIT]
                       && !ext_clock_source_o && (pins_rd[7:6] == 2'b00))
      else $error("crystal pins still digital");

   tmr_digital_a: assert property (
      !analog_pin_mask[PA_TMR_BIT])
      else $error("bit 4 claimed as analog");

   analog_sel_a: assert property (
      ((ancfg_q[PA_PCFG_W-1:0] >= PA_PCFG_W'(PA_PCFG_ALL_DIG)) |-> (analog_en_o == '0))
      and ((ancfg_q[PA_PCFG_W-1:0] == '0) |-> (analog_en_o == PA_AN_ALL)))
      else $error("selector decode of analog channels wrong");

endmodule : pap_port_a

// >>> hw/pap_sync2.sv
`timescale 1ns/1ps
module pap_sync2
   import pap_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // levels
   input wire logic [PA_W-1:0] async_i,
   output logic [PA_W-1:0] sync_o
);

   // first stage is read only by the second stage
   logic [PA_W-1:0] meta_q;
   logic [PA_W-1:0] sync_q;

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= PA_NO_PINS;
         sync_q <= PA_NO_PINS;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule : pap_sync2
